// ===== tb/tb_equalizer_compressor_control.sv
`include "eqcc_regs.svh"
module tb_equalizer_compressor_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
   logic [15:0] awaddr, araddr, c1, c2, rate;
   logic [31:0] wdata, rdata;
   logic [3:0] filt_act, comp_act;
   logic [1:0] sd, bresp, rresp, sde;
   logic awready, wready, bvalid, arready, rvalid, wseq;
   logic [2:0] eq_act, eq_peak;
   logic [74:0] gain;
   int failures, tests_run;

   eqcc_top uut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready),
      .LOWPASS_HIGHPASS_FILTER_ACTIVE(filt_act),
      .COMP_SIGNAL_DETECT(sd), .EQ_ACTIVE(eq_act),
      .EQ_BAND1_PEAK(eq_peak), .EQ_GAIN_DB(gain), .COMP_ACTIVE(comp_act),
      .COMP1_CONTROL(c1), .COMP2_CONTROL(c2), .EFFECTS_SAMPLE_RATE(rate),
      .SIGNAL_DETECT_EVENT(sde), .WSEQ_TRIGGER(wseq));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [15:0] ba(input logic [11:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string n, input logic [74:0] e,
                      input logic [74:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask

   // axi write, both channels offered together
   task automatic wr(input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do begin
         @(posedge clk);
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk($sformatf("bresp %h", a), er, bresp);
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] e,
                     input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin
         @(posedge clk);
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk($sformatf("rdata %h", a), {16'h0000, e}, rdata);
      chk($sformatf("rresp %h", a), er, rresp);
   endtask

   task automatic t_reset;
      for (int k = 0; k < 3; k++) begin
         rd(ba(`EQCC_IDX_EQ2_A + 12'(k) * 12'h016), 16'h6318, 2'h0);
         rd(ba(`EQCC_IDX_EQ2_B + 12'(k) * 12'h016), 16'h6300, 2'h0);
      end
      rd(ba(`EQCC_IDX_COMP1), 16'h0018, 2'h0);
      rd(ba(`EQCC_IDX_COMP2), 16'h0018, 2'h0);
      rd(ba(`EQCC_IDX_STATUS), 16'h00a0, 2'h0);
      chk("gain at reset", 75'h0, gain);
      chk("eq active at reset", 3'h0, eq_act);
      chk("comp active at reset", 4'h0, comp_act);
   endtask

   task automatic t_gain;
      wr(ba(`EQCC_IDX_EQ2_A), 16'h0616, 2'h0);
      wr(ba(`EQCC_IDX_EQ3_B), 16'hfb41, 2'h0);
      repeat (2) @(posedge clk);
      chk("eq2 band1", 5'h14, gain[4:0]);
      chk("eq2 band2", 5'h0c, gain[9:5]);
      chk("eq2 band3", 5'h1f, gain[14:10]);
      chk("eq3 band4", 5'h0c, gain[44:40]);
      chk("eq3 band5", 5'h01, gain[49:45]);
      chk("eq3 band1", 5'h00, gain[29:25]);
      chk("band1 peak", 3'h2, eq_peak);
      rd(ba(`EQCC_IDX_EQ3_B), 16'hfb41, 2'h0);
   endtask

   task automatic t_grant;
      wr(ba(`EQCC_IDX_EQ2_A), 16'h0617, 2'h0);
      wr(ba(`EQCC_IDX_EQ3_A), 16'h6319, 2'h0);
      wr(ba(`EQCC_IDX_EQ4_A), 16'h6319, 2'h0);
      wr(ba(`EQCC_IDX_COMP1), 16'h001b, 2'h0);
      wr(ba(`EQCC_IDX_COMP2), 16'h001b, 2'h0);
      @(posedge clk);
      chk("eq active", 3'h7, eq_act);
      chk("comp active", 4'h3, comp_act);
      chk("comp1 word out", 16'h001b, c1);
      chk("comp2 word out", 16'h001b, c2);
      rd(ba(`EQCC_IDX_STATUS), 16'he3a0, 2'h0);
      rd(ba(`EQCC_IDX_COMP2), 16'h001b, 2'h0);
      wr(ba(`EQCC_IDX_CAP), 16'h0000, 2'h0);
      @(posedge clk);
      chk("paths after budget cut", 7'h73, {eq_act, comp_act});
      // eq3 off, then a request that the empty budget refuses
      wr(ba(`EQCC_IDX_EQ3_A), 16'h6318, 2'h0);
      wr(ba(`EQCC_IDX_EQ3_A), 16'h6319, 2'h0);
      @(posedge clk);
      chk("eq3 refused", 7'h53, {eq_act, comp_act});
      rd(ba(`EQCC_IDX_EQ3_A), 16'h6319, 2'h0);
      wr(ba(`EQCC_IDX_CAP), 16'h0010, 2'h0);
      wr(ba(`EQCC_IDX_EQ4_A), 16'h6318, 2'h0);
      wr(ba(`EQCC_IDX_COMP2), 16'h001a, 2'h0);
      wr(ba(`EQCC_IDX_COMP2), 16'h001b, 2'h0);
      @(posedge clk);
      chk("comp active retry", 4'hb, comp_act);
      rd(ba(`EQCC_IDX_STATUS), 16'h2ba0, 2'h0);
      wr(ba(`EQCC_IDX_STATUS), 16'hffff, 2'h0);
      rd(ba(`EQCC_IDX_STATUS), 16'h2ba0, 2'h0);
   endtask

   task automatic t_map;
      rd(16'h0000, 16'h0000, 2'h2);
      wr(16'h4000 | ba(`EQCC_IDX_COMP1), 16'h0000, 2'h2);
      rd(ba(`EQCC_IDX_COMP1), 16'h001b, 2'h0);
      wr(ba(12'he50), 16'h5a5a, 2'h0);
      rd(ba(12'he50), 16'h5a5a, 2'h0);
      wr(ba(12'he3a), 16'ha5c3, 2'h0);
      rd(ba(12'he3a), 16'ha5c3, 2'h0);
      rd(ba(12'he3b), 16'h0000, 2'h2);
      rd(ba(12'h8e0), 16'h0000, 2'h2);
   endtask

   task automatic t_rate;
      // sources cleared first, then the settle gap
      for (int k = 0; k < 32; k++) begin
         wr(ba(`EQCC_IDX_MIX + 12'(k)), 16'h0000, 2'h0);
      end
      rd(ba(12'h8df), 16'h0000, 2'h0);
      repeat (5000) @(posedge clk);
      wr(ba(`EQCC_IDX_RATE), 16'h0004, 2'h0);
      @(posedge clk);
      chk("rate out", 16'h0004, rate);
      rd(ba(`EQCC_IDX_RATE), 16'h0004, 2'h0);
   endtask

   task automatic det(input int i, input int ev, input int ws);
      int ne, nw;
      ne = 0;
      nw = 0;
      @(posedge clk);
      sd[i] <= 1'b1;
      repeat (4) begin
         @(posedge clk);
         if (sde[i] === 1'b1) ne++;
         if (wseq === 1'b1) nw++;
      end
      sd[i] <= 1'b0;
      repeat (3) @(posedge clk);
      chk($sformatf("event %0d", i), ev, ne);
      chk($sformatf("wseq %0d", i), ws, nw);
   endtask

   task automatic t_detect;
      wr(ba(`EQCC_IDX_COMP1), 16'h005f, 2'h0);
      wr(ba(`EQCC_IDX_COMP2), 16'h005f, 2'h0);
      det(0, 1, 1);
      det(1, 1, 0);
      wr(ba(`EQCC_IDX_COMP1), 16'h001f, 2'h0);
      det(0, 0, 0);
      chk("comp active kept", 4'hb, comp_act);
   endtask

   initial begin
      rst = 1'b1;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 16'h0000;
      araddr = 16'h0000;
      wdata = 32'h00000000;
      filt_act = 4'ha;
      sd = 2'h0;
      failures = 0;
      tests_run = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_gain;
      t_grant;
      t_map;
      t_rate;
      t_detect;
      conclude;
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude;
   end
endmodule // tb_equalizer_compressor_control

// ===== verilog/eqcc_pkg.sv
`include "eqcc_regs.svh"
package eqcc_pkg;
   typedef logic [4:0] eqcc_code_t;
   typedef logic signed [4:0] eqcc_db_t;
   typedef logic [15:0] eqcc_word_t;

   // code to signed dB, reserved codes clamp to top
   function automatic eqcc_db_t eqcc_decode(input eqcc_code_t c);
      eqcc_code_t v;
      v = (c > `EQCC_GAIN_MAX) ? `EQCC_GAIN_MAX : c;
      return eqcc_db_t'(v - `EQCC_GAIN_ZERO);
   endfunction
endpackage

// ===== verilog/eqcc_regs.svh
`ifndef EQCC_REGS_SVH
`define EQCC_REGS_SVH
// register indices, byte address is index times four
`define EQCC_IDX_RATE 12'he00
`define EQCC_IDX_STATUS 12'he01
`define EQCC_IDX_CAP 12'he02
`define EQCC_IDX_EQ2_A 12'he26
`define EQCC_IDX_EQ2_B 12'he27
`define EQCC_IDX_EQ2_C 12'he28
`define EQCC_IDX_EQ3_A 12'he3c
`define EQCC_IDX_EQ3_B 12'he3d
`define EQCC_IDX_EQ3_C 12'he3e
`define EQCC_IDX_EQ4_A 12'he52
`define EQCC_IDX_EQ4_B 12'he53
`define EQCC_IDX_EQ4_C 12'he54
`define EQCC_IDX_COMP1 12'he80
`define EQCC_IDX_COMP2 12'he88
`define EQCC_IDX_MIX 12'h8c0
`define EQCC_COEF_WORDS 12'h013
`define EQCC_MIX_WORDS 12'h020
// field positions
`define EQCC_G_HI_1 15
`define EQCC_G_LO_1 11
`define EQCC_G_HI_2 10
`define EQCC_G_LO_2 6
`define EQCC_G_HI_3 5
`define EQCC_G_LO_3 1
`define EQCC_ENA_BIT 0
`define EQCC_MODE_BIT 0
`define EQCC_LEFT_BIT 1
`define EQCC_RIGHT_BIT 0
`define EQCC_WSEQ_BIT 2
`define EQCC_SIGDET_BIT 6
// reset values and codes
`define EQCC_EQ_A_RST 16'h6318
`define EQCC_EQ_B_RST 16'h6300
`define EQCC_COMP_RST 16'h0018
`define EQCC_RATE_RST 16'h0000
`define EQCC_CAP_RST 16'h0010
`define EQCC_EQ_COST 16'h0004
`define EQCC_COMP_COST 16'h0002
`define EQCC_GAIN_ZERO 5'h0c
`define EQCC_GAIN_MAX 5'h18
`define EQCC_RESP_OKAY 2'h0
`define EQCC_RESP_SLVERR 2'h2
`endif

// ===== verilog/eqcc_top.sv
// Design decision made here: the AXI4-Lite register port.
`include "eqcc_regs.svh"
module eqcc_top (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [15:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [15:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [3:0] LOWPASS_HIGHPASS_FILTER_ACTIVE,
   input wire logic [1:0] COMP_SIGNAL_DETECT,
   output logic [2:0] EQ_ACTIVE,
   output logic [2:0] EQ_BAND1_PEAK,
   output logic [74:0] EQ_GAIN_DB,
   output logic [3:0] COMP_ACTIVE,
   output logic [15:0] COMP1_CONTROL,
   output logic [15:0] COMP2_CONTROL,
   output logic [15:0] EFFECTS_SAMPLE_RATE,
   output logic [1:0] SIGNAL_DETECT_EVENT,
   output logic WSEQ_TRIGGER
);
   localparam int NE = 3;
   localparam int NW = NE * int'(`EQCC_COEF_WORDS);
   localparam logic [11:0] AIDX [NE] = '{`EQCC_IDX_EQ2_A,
      `EQCC_IDX_EQ3_A, `EQCC_IDX_EQ4_A};
   localparam logic [11:0] BIDX [NE] = '{`EQCC_IDX_EQ2_B,
      `EQCC_IDX_EQ3_B, `EQCC_IDX_EQ4_B};
   localparam logic [11:0] CIDX [NE] = '{`EQCC_IDX_EQ2_C,
      `EQCC_IDX_EQ3_C, `EQCC_IDX_EQ4_C};
   localparam logic [11:0] PIDX [2] = '{`EQCC_IDX_COMP1,
      `EQCC_IDX_COMP2};

   default clocking dclk @(posedge CLK);
   endclocking
   default disable iff (RST);

   eqcc_pkg::eqcc_word_t eq_a_q [NE];
   eqcc_pkg::eqcc_word_t eq_a_d [NE];
   eqcc_pkg::eqcc_word_t eq_b_q [NE];
   eqcc_pkg::eqcc_word_t eq_b_d [NE];
   eqcc_pkg::eqcc_word_t comp_q [2];
   eqcc_pkg::eqcc_word_t comp_d [2];
   eqcc_pkg::eqcc_word_t rate_q, rate_d, cap_q, cap_d, load, nload, nv;
   eqcc_pkg::eqcc_word_t coef_mem [NW];
   eqcc_pkg::eqcc_word_t mix_mem [32];
   logic [NE-1:0] eq_on_q, eq_on_d;
   logic [3:0] comp_on_q, comp_on_d;
   logic [74:0] gain_d;
   logic [1:0] det_q, ev_d;
   logic wseq_d;
   logic coef_we, mix_we, hit, do_write, rhit;
   logic [6:0] coef_wi, coef_ri;
   logic [4:0] mix_wi;
   logic [11:0] widx, ridx;
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic [15:0] aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d, rdata_d;
   logic [3:0] w_strb_q, w_strb_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [15:0] rword;

   function automatic logic [15:0] merge(input logic [15:0] o);
      merge = o;
      if (w_strb_q[0]) merge[7:0] = w_data_q[7:0];
      if (w_strb_q[1]) merge[15:8] = w_data_q[15:8];
   endfunction

   // msb flags a hit, low bits index the coefficient array
   function automatic logic [6:0] coef_slot(input logic [11:0] i);
      coef_slot = 7'h00;
      for (int k = 0; k < NE; k++) begin
         if (i >= CIDX[k] && i < CIDX[k] + `EQCC_COEF_WORDS) begin
            coef_slot = {1'b1, 6'(k * int'(`EQCC_COEF_WORDS)
               + int'(i - CIDX[k]))};
         end
      end
   endfunction

   // clock budget taken by paths already running
   always_comb begin
      load = 16'h0000;
      for (int k = 0; k < NE; k++) begin
         if (eq_on_q[k]) load = load + `EQCC_EQ_COST;
      end
      for (int c = 0; c < 4; c++) begin
         if (comp_on_q[c]) load = load + `EQCC_COMP_COST;
      end
   end

   assign S_AXI_AWREADY = !aw_held_q;
   assign S_AXI_WREADY = !w_held_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign widx = aw_addr_q[13:2];
   assign ridx = S_AXI_ARADDR[13:2];

   always_comb begin
      aw_held_d = aw_held_q;
      aw_addr_d = aw_addr_q;
      w_held_d = w_held_q;
      w_data_d = w_data_q;
      w_strb_d = w_strb_q;
      if (S_AXI_AWVALID && !aw_held_q) begin
         aw_held_d = 1'b1;
         aw_addr_d = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held_q) begin
         w_held_d = 1'b1;
         w_data_d = S_AXI_WDATA;
         w_strb_d = S_AXI_WSTRB;
      end
      if (do_write) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
      end
      bvalid_d = bvalid_q;
      if (do_write) bvalid_d = 1'b1;
      else if (S_AXI_BREADY) bvalid_d = 1'b0;
   end

   // register writes and enable grants
   always_comb begin
      eq_a_d = eq_a_q;
      eq_b_d = eq_b_q;
      comp_d = comp_q;
      rate_d = rate_q;
      cap_d = cap_q;
      eq_on_d = eq_on_q;
      comp_on_d = comp_on_q;
      nload = load;
      nv = 16'h0000;
      hit = 1'b0;
      coef_we = 1'b0;
      coef_wi = coef_slot(widx);
      mix_we = 1'b0;
      mix_wi = widx[4:0];
      bresp_d = bresp_q;
      if (do_write && aw_addr_q[15:14] == 2'h0) begin
         for (int k = 0; k < NE; k++) begin
            if (widx == AIDX[k]) begin
               hit = 1'b1;
               nv = merge(eq_a_q[k]);
               eq_a_d[k] = nv;
               if (!nv[`EQCC_ENA_BIT]) begin
                  eq_on_d[k] = 1'b0;
               end else if (!eq_a_q[k][`EQCC_ENA_BIT] &&
                            nload + `EQCC_EQ_COST <= cap_q) begin
                  eq_on_d[k] = 1'b1;
                  nload = nload + `EQCC_EQ_COST;
               end
            end
            if (widx == BIDX[k]) begin
               hit = 1'b1;
               eq_b_d[k] = merge(eq_b_q[k]);
            end
         end
         for (int c = 0; c < 2; c++) begin
            if (widx == PIDX[c]) begin
               hit = 1'b1;
               nv = merge(comp_q[c]);
               comp_d[c] = nv;
               for (int j = 0; j < 2; j++) begin
                  if (!nv[`EQCC_LEFT_BIT - j]) begin
                     comp_on_d[c*2+j] = 1'b0;
                  end else if (!comp_q[c][`EQCC_LEFT_BIT - j] &&
                               nload + `EQCC_COMP_COST <= cap_q) begin
                     comp_on_d[c*2+j] = 1'b1;
                     nload = nload + `EQCC_COMP_COST;
                  end
               end
            end
         end
         if (widx == `EQCC_IDX_RATE) begin
            hit = 1'b1;
            rate_d = merge(rate_q);
         end
         if (widx == `EQCC_IDX_CAP) begin
            hit = 1'b1;
            cap_d = merge(cap_q);
         end
         if (widx == `EQCC_IDX_STATUS) hit = 1'b1;
         if (widx >= `EQCC_IDX_MIX &&
             widx < `EQCC_IDX_MIX + `EQCC_MIX_WORDS) begin
            hit = 1'b1;
            mix_we = 1'b1;
         end
         if (coef_wi[6]) begin
            hit = 1'b1;
            coef_we = 1'b1;
         end
      end
      if (do_write) bresp_d = hit ? `EQCC_RESP_OKAY : `EQCC_RESP_SLVERR;
   end

   // read mux
   always_comb begin
      rword = 16'h0000;
      rhit = S_AXI_ARADDR[15:14] == 2'h0;
      coef_ri = coef_slot(ridx);
      if (ridx == `EQCC_IDX_RATE) begin
         rword = rate_q;
      end else if (ridx == `EQCC_IDX_CAP) begin
         rword = cap_q;
      end else if (ridx == `EQCC_IDX_STATUS) begin
         rword = {eq_on_q, 1'b0, comp_on_q,
            LOWPASS_HIGHPASS_FILTER_ACTIVE, 4'h0};
      end else if (ridx == PIDX[0]) begin
         rword = comp_q[0];
      end else if (ridx == PIDX[1]) begin
         rword = comp_q[1];
      end else if (ridx >= `EQCC_IDX_MIX &&
                   ridx < `EQCC_IDX_MIX + `EQCC_MIX_WORDS) begin
         rword = mix_mem[ridx[4:0]];
      end else if (coef_ri[6]) begin
         rword = coef_mem[coef_ri[5:0]];
      end else begin
         rhit = 1'b0;
         for (int k = 0; k < NE; k++) begin
            if (ridx == AIDX[k]) begin
               rword = eq_a_q[k];
               rhit = S_AXI_ARADDR[15:14] == 2'h0;
            end
            if (ridx == BIDX[k]) begin
               rword = eq_b_q[k];
               rhit = S_AXI_ARADDR[15:14] == 2'h0;
            end
         end
      end
      rvalid_d = rvalid_q;
      rdata_d = S_AXI_RDATA;
      rresp_d = rresp_q;
      if (S_AXI_ARVALID && !rvalid_q) begin
         rvalid_d = 1'b1;
         rdata_d = rhit ? {16'h0000, rword} : 32'h0000_0000;
         rresp_d = rhit ? `EQCC_RESP_OKAY : `EQCC_RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         rvalid_d = 1'b0;
      end
   end

   always_comb begin
      gain_d = '0;
      for (int k = 0; k < NE; k++) begin
         gain_d[k*25 +: 5] = eqcc_pkg::eqcc_decode(
            eq_a_q[k][`EQCC_G_HI_1:`EQCC_G_LO_1]);
         gain_d[k*25+5 +: 5] = eqcc_pkg::eqcc_decode(
            eq_a_q[k][`EQCC_G_HI_2:`EQCC_G_LO_2]);
         gain_d[k*25+10 +: 5] = eqcc_pkg::eqcc_decode(
            eq_a_q[k][`EQCC_G_HI_3:`EQCC_G_LO_3]);
         gain_d[k*25+15 +: 5] = eqcc_pkg::eqcc_decode(
            eq_b_q[k][`EQCC_G_HI_1:`EQCC_G_LO_1]);
         gain_d[k*25+20 +: 5] = eqcc_pkg::eqcc_decode(
            eq_b_q[k][`EQCC_G_HI_2:`EQCC_G_LO_2]);
      end
   end

   // detect events, sequencer from first only
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         ev_d[c] = COMP_SIGNAL_DETECT[c] && !det_q[c] &&
            comp_q[c][`EQCC_SIGDET_BIT];
      end
      wseq_d = ev_d[0] && comp_q[0][`EQCC_WSEQ_BIT];
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         for (int k = 0; k < NE; k++) begin
            eq_a_q[k] <= `EQCC_EQ_A_RST;
            eq_b_q[k] <= `EQCC_EQ_B_RST;
         end
         comp_q[0] <= `EQCC_COMP_RST;
         comp_q[1] <= `EQCC_COMP_RST;
         rate_q <= `EQCC_RATE_RST;
         cap_q <= `EQCC_CAP_RST;
         eq_on_q <= '0;
         comp_on_q <= '0;
         EQ_GAIN_DB <= '0;
         det_q <= '0;
         SIGNAL_DETECT_EVENT <= '0;
         WSEQ_TRIGGER <= 1'b0;
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_held_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= `EQCC_RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q <= `EQCC_RESP_OKAY;
         S_AXI_RDATA <= '0;
      end else begin
         eq_a_q <= eq_a_d;
         eq_b_q <= eq_b_d;
         comp_q <= comp_d;
         rate_q <= rate_d;
         cap_q <= cap_d;
         eq_on_q <= eq_on_d;
         comp_on_q <= comp_on_d;
         EQ_GAIN_DB <= gain_d;
         det_q <= COMP_SIGNAL_DETECT;
         SIGNAL_DETECT_EVENT <= ev_d;
         WSEQ_TRIGGER <= wseq_d;
         aw_held_q <= aw_held_d;
         aw_addr_q <= aw_addr_d;
         w_held_q <= w_held_d;
         w_data_q <= w_data_d;
         w_strb_q <= w_strb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         S_AXI_RDATA <= rdata_d;
      end
   end

   always_ff @(posedge CLK) begin
      if (coef_we) coef_mem[coef_wi[5:0]] <= merge(coef_mem[coef_wi[5:0]]);
      if (mix_we) mix_mem[mix_wi] <= merge(mix_mem[mix_wi]);
   end

   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RRESP = rresp_q;
   assign EQ_ACTIVE = eq_on_q;
   assign COMP_ACTIVE = comp_on_q;
   // feature controls to the compressor core
   assign COMP1_CONTROL = comp_q[0];
   assign COMP2_CONTROL = comp_q[1];
   assign EFFECTS_SAMPLE_RATE = rate_q;
   always_comb begin
      for (int k = 0; k < NE; k++) begin
         EQ_BAND1_PEAK[k] = eq_b_q[k][`EQCC_MODE_BIT];
      end
   end

   AST_RESET_GAIN: assert property ($past(RST) |->
      eq_a_q[0] == `EQCC_EQ_A_RST && eq_b_q[2] == `EQCC_EQ_B_RST
      && eq_on_q == '0) else $error("gain reset wrong");
   AST_RESET_COMP: assert property ($past(RST) |->
      comp_q[0] == `EQCC_COMP_RST && comp_q[1] == `EQCC_COMP_RST)
      else $error("compressor reset wrong");
   AST_ON_NEEDS_REQ: assert property (eq_on_q[0] |->
      eq_a_q[0][`EQCC_ENA_BIT]) else $error("path on unrequested");
   AST_REFUSE: assert property (do_write && widx == AIDX[1] &&
      !eq_a_q[1][`EQCC_ENA_BIT] && !eq_on_q[1] &&
      load + `EQCC_EQ_COST > cap_q |=> !eq_on_q[1])
      else $error("enable not refused");
   AST_KEEP_RUNNING: assert property (eq_on_q[0] &&
      !(do_write && widx == AIDX[0]) |=> eq_on_q[0])
      else $error("running path disturbed");
   AST_STATUS_READ: assert property (S_AXI_ARVALID &&
      !rvalid_q && S_AXI_ARADDR == {2'h0, `EQCC_IDX_STATUS, 2'h0}
      |=> S_AXI_RDATA[15:8] == {$past(eq_on_q), 1'b0, $past(comp_on_q)})
      else $error("status read mismatch");
   AST_GAIN_TOP: assert property (
      eq_b_q[1][`EQCC_G_HI_1:`EQCC_G_LO_1] >= `EQCC_GAIN_MAX
      |=> EQ_GAIN_DB[44:40] == 5'h0c) else $error("clamp fail");
   AST_GAIN_ZERO: assert property (
      eq_b_q[1][`EQCC_G_HI_2:`EQCC_G_LO_2] == `EQCC_GAIN_ZERO
      |=> EQ_GAIN_DB[49:45] == 5'h00) else $error("0 dB decode wrong");
   AST_WSEQ_FIRST: assert property (WSEQ_TRIGGER |->
      SIGNAL_DETECT_EVENT[0] && $past(comp_q[0][`EQCC_WSEQ_BIT]))
      else $error("sequencer trigger not from first");
   AST_BRESP: assert property (do_write |=> S_AXI_BVALID)
      else $error("no write response");
   COV_GRANT: cover property (!eq_on_q[0] ##1 eq_on_q[0]);
   COV_REFUSE: cover property (do_write && widx == AIDX[2] &&
      !eq_a_q[2][`EQCC_ENA_BIT] ##1 eq_a_q[2][`EQCC_ENA_BIT] && !eq_on_q[2]);
   COV_COMP: cover property (comp_on_q == 4'hf);
   COV_WSEQ: cover property (WSEQ_TRIGGER);
endmodule // eqcc_top
